// ==== rtl/event_count_pkg.sv ====
// Constants for the external event count channel: register map, field
// positions, reset values and prescaler tap settings.
// Assumes a 32-bit Avalon-MM register port addressed in words.
`default_nettype none

package event_count_pkg;

  // ==========================================================
  // Register word addresses
  localparam logic [2:0] ADDR_MODE_CFG = 3'h0; // channel_mode_config
  localparam logic [2:0] ADDR_EDGE_CFG = 3'h1; // channel_edge_config
  localparam logic [2:0] ADDR_RELOAD = 3'h2; // reload_data
  localparam logic [2:0] ADDR_COUNTER = 3'h3; // down_counter, read only
  localparam logic [2:0] ADDR_START = 3'h4; // start_trigger_reg
  localparam logic [2:0] ADDR_STOP = 3'h5; // stop_trigger_reg
  localparam logic [2:0] ADDR_ENABLE = 3'h6; // enable_status_reg, read only

  // ==========================================================
  // Widths
  localparam int CNT_W = 32; // Counter and reload width
  localparam int MODE_W = 16; // Channel mode register width
  localparam int EDGE_W = 8; // Edge config register width

  // ==========================================================
  // Field positions in channel_mode_config
  localparam int OPCLK_SEL_LSB = 14; // operation_clock_select [15:14]
  localparam int CLK_SRC_LSB = 12; // count_clock_source [13:12]
  localparam int MASTER_SEL_BIT = 11; // master_select
  localparam int TRIG_SRC_LSB = 8; // start_trigger_source [10:8]
  localparam int CAP_OVF_LSB = 6; // capture_overflow_select [7:6]
  localparam int OP_MODE_LSB = 1; // operating_mode_field [4:1]
  localparam int START_IRQ_BIT = 0; // start_interrupt_select
  localparam logic [15:0] MODE_WR_MASK = 16'hffdf; // Bit 5 reads zero

  // Field position in channel_edge_config
  localparam int EDGE_SEL_LSB = 0; // edge_select [1:0]

  // ==========================================================
  // Edge select codes
  localparam logic [1:0] EDGE_FALL = 2'h0;
  localparam logic [1:0] EDGE_RISE = 2'h1;
  localparam logic [1:0] EDGE_BOTH = 2'h2;

  // ==========================================================
  // Reset values
  localparam logic [15:0] MODE_RST = 16'h0000;
  localparam logic [7:0] EDGE_RST = 8'h00;
  localparam logic [31:0] RELOAD_RST = 32'h0000_0000;
  localparam logic [31:0] COUNT_RST = 32'h0000_0000;

  // ==========================================================
  // Prescaler: output n ticks every 2**PRESC_SHIFTn cycles
  localparam int PRESC_W = 8;
  localparam int PRESC_SHIFT0 = 0;
  localparam int PRESC_SHIFT1 = 2;
  localparam int PRESC_SHIFT2 = 4;
  localparam int PRESC_SHIFT3 = 6;

endpackage

`default_nettype wire

// ==== rtl/external_event_counter.sv ====
// External event count channel: a down counter reloaded from reload_data,
// stepped by selected edges of event_input, pulsing channel_interrupt.
// Assumes an Avalon-MM master on ref_clk and an asynchronous event pin.
//
// Summary of operation
// - Start trigger sets enable and loads counter
// - Each effective edge decrements counter by one
// - Zero on edge: interrupt, reload, keep counting
// - Stop trigger clears enable, counter holds value
// - Start while stopped reloads and resumes counting
// - Start while running forces immediate reload
// - Trigger bits clear themselves after writing
// - New reload value used only at reload
// - Edge select: 00 fall, 01 rise, 10 both
// - Counter readable anytime without disturbing counting
// - Clock select picks prescaler output 0 to 3
// - Channel output plays no part here
// - Stopped channel ignores edges, counter unchanged
// - Reload zero: interrupt on every edge
// - After forced restart wait for next edge
`timescale 1ns/10ps
`default_nettype none

module external_event_counter (
  // Clock and reset
  input wire logic ref_clk,
  input wire logic srst,
  // Avalon-MM slave
  input wire logic [2:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [3:0] avs_byteenable,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  // Event pin
  input wire logic event_input,
  // Channel outputs
  output logic channel_interrupt,
  output logic channel_output
);

  // ==========================================================
  // Helper functions

  // Merge write data into a register under byte enables
  function automatic logic [31:0] merge_be(input logic [31:0] old_val, input logic [31:0] new_val,
                                           input logic [3:0] be);
    logic [31:0] res;
    res = old_val;
    for (int i = 0; i < 4; i++) begin
      if (be[i]) begin
        res[i*8 +: 8] = new_val[i*8 +: 8];
      end
    end
    return res;
  endfunction

  // True when the low shift bits of the prescaler are all ones
  function automatic logic presc_tick(input logic [event_count_pkg::PRESC_W-1:0] cnt, input int shift);
    logic all_ones;
    all_ones = 1'b1;
    for (int i = 0; i < event_count_pkg::PRESC_W; i++) begin
      if (i < shift && !cnt[i]) begin
        all_ones = 1'b0;
      end
    end
    return all_ones;
  endfunction

  // ==========================================================
  // Registers and state
  logic [15:0] mode_cfg_ff; // channel_mode_config
  logic [7:0] edge_cfg_ff; // channel_edge_config
  logic [31:0] reload_ff; // reload_data
  logic [31:0] down_counter_ff; // down_counter
  logic enable_ff; // enable_status_bit
  logic irq_ff; // channel_interrupt pulse
  logic ack_ff; // Bus answer phase
  logic [31:0] rdata_ff; // Registered read data
  logic [event_count_pkg::PRESC_W-1:0] presc_ff; // Free running prescaler
  logic sync1_ff, sync2_ff, sync3_ff; // Pin synchroniser
  logic level_ff; // Filtered input level

  // Decoded strobes
  logic bus_req; // Request pending
  logic wr_done; // Write takes effect this edge
  logic start_wr; // Write of 1 to start_trigger_bit
  logic stop_wr; // Write of 1 to stop_trigger_bit
  logic op_tick; // Selected operation clock enable
  logic stable_in; // Stages two and three agree
  logic raw_rise, raw_fall; // Filtered level changes
  logic eff_edge; // Effective edge pulse
  logic [1:0] edge_select; // edge_select field
  logic [1:0] opclk_sel; // operation_clock_select field

  assign edge_select = edge_cfg_ff[event_count_pkg::EDGE_SEL_LSB +: 2];
  assign opclk_sel = mode_cfg_ff[event_count_pkg::OPCLK_SEL_LSB +: 2];

  // ==========================================================
  // Avalon-MM handshake
  // One wait cycle on every access, so read data can be registered
  assign bus_req = avs_read | avs_write;
  assign avs_waitrequest = bus_req & ~ack_ff;
  assign wr_done = avs_write & ack_ff;
  // Trigger bits have no storage, so they read back zero
  assign start_wr = wr_done && avs_address == event_count_pkg::ADDR_START && avs_byteenable[0]
                    && avs_writedata[0];
  assign stop_wr = wr_done && avs_address == event_count_pkg::ADDR_STOP && avs_byteenable[0]
                   && avs_writedata[0];

  // Answer phase toggles once per accepted request
  always_ff @(posedge ref_clk) begin
    if (srst) begin
      ack_ff <= 1'b0;
    end else begin
      ack_ff <= bus_req & ~ack_ff;
    end
  end

  // Read mux, sampled in the wait cycle; counter read has no side effect
  always_ff @(posedge ref_clk) begin
    if (srst) begin
      rdata_ff <= 32'h0000_0000;
    end else if (avs_read && !ack_ff) begin
      unique case (avs_address)
        event_count_pkg::ADDR_MODE_CFG: rdata_ff <= {16'h0000, mode_cfg_ff};
        event_count_pkg::ADDR_EDGE_CFG: rdata_ff <= {24'h000000, edge_cfg_ff};
        event_count_pkg::ADDR_RELOAD: rdata_ff <= reload_ff;
        event_count_pkg::ADDR_COUNTER: rdata_ff <= down_counter_ff;
        event_count_pkg::ADDR_ENABLE: rdata_ff <= {31'h0000_0000, enable_ff};
        // Triggers and unmapped addresses read zero
        default: rdata_ff <= 32'h0000_0000;
      endcase
    end
  end
  assign avs_readdata = rdata_ff;

  // ==========================================================
  // Configuration registers
  // Mode fields other than the clock select are stored for software only
  always_ff @(posedge ref_clk) begin
    if (srst) begin
      mode_cfg_ff <= event_count_pkg::MODE_RST;
      edge_cfg_ff <= event_count_pkg::EDGE_RST;
    end else if (wr_done) begin
      if (avs_address == event_count_pkg::ADDR_MODE_CFG) begin
        mode_cfg_ff <= 16'(merge_be({16'h0000, mode_cfg_ff}, avs_writedata, avs_byteenable))
                       & event_count_pkg::MODE_WR_MASK;
      end
      if (avs_address == event_count_pkg::ADDR_EDGE_CFG && avs_byteenable[0]) begin
        // Bits 7..2 are fixed at zero
        edge_cfg_ff <= {6'h00, avs_writedata[1:0]};
      end
    end
  end

  // Reload value may change anytime; only read at a load
  always_ff @(posedge ref_clk) begin
    if (srst) begin
      reload_ff <= event_count_pkg::RELOAD_RST;
    end else if (wr_done && avs_address == event_count_pkg::ADDR_RELOAD) begin
      reload_ff <= merge_be(reload_ff, avs_writedata, avs_byteenable);
    end
  end

  // ==========================================================
  // Prescaler and operation clock select
  always_ff @(posedge ref_clk) begin
    if (srst) begin
      presc_ff <= '0;
    end else begin
      presc_ff <= presc_ff + 1'b1;
    end
  end

  // Pick prescaler output 0..3 as the sampling enable
  always_comb begin
    unique case (opclk_sel)
      2'h0: op_tick = presc_tick(presc_ff, event_count_pkg::PRESC_SHIFT0);
      2'h1: op_tick = presc_tick(presc_ff, event_count_pkg::PRESC_SHIFT1);
      2'h2: op_tick = presc_tick(presc_ff, event_count_pkg::PRESC_SHIFT2);
      2'h3: op_tick = presc_tick(presc_ff, event_count_pkg::PRESC_SHIFT3);
    endcase
  end

  // ==========================================================
  // Event input synchroniser and edge detection
  // Three stages; a change counts when stages two and three agree
  always_ff @(posedge ref_clk) begin
    if (srst) begin
      sync1_ff <= 1'b0;
      sync2_ff <= 1'b0;
      sync3_ff <= 1'b0;
    end else begin
      sync1_ff <= event_input;
      sync2_ff <= sync1_ff;
      sync3_ff <= sync2_ff;
    end
  end

  assign stable_in = (sync2_ff == sync3_ff);

  // Filtered level only moves on an operation clock tick
  always_ff @(posedge ref_clk) begin
    if (srst) begin
      level_ff <= 1'b0;
    end else if (op_tick && stable_in) begin
      level_ff <= sync3_ff;
    end
  end

  // Compare new and previous samples
  assign raw_rise = op_tick && stable_in && sync3_ff && !level_ff;
  assign raw_fall = op_tick && stable_in && !sync3_ff && level_ff;

  // Edge polarity from edge_select; code 11 counts nothing
  always_comb begin
    unique case (edge_select)
      event_count_pkg::EDGE_FALL: eff_edge = raw_fall;
      event_count_pkg::EDGE_RISE: eff_edge = raw_rise;
      event_count_pkg::EDGE_BOTH: eff_edge = raw_rise | raw_fall;
      default: eff_edge = 1'b0;
    endcase
  end

  // ==========================================================
  // Enable status
  // Start sets, stop clears; they sit at separate addresses so never coincide
  always_ff @(posedge ref_clk) begin
    if (srst) begin
      enable_ff <= 1'b0;
    end else if (start_wr) begin
      enable_ff <= 1'b1;
    end else if (stop_wr) begin
      enable_ff <= 1'b0;
    end
  end

  // ==========================================================
  // Down counter
  // A start trigger beats a coincident edge: the fresh value waits for the next edge
  always_ff @(posedge ref_clk) begin
    if (srst) begin
      down_counter_ff <= event_count_pkg::COUNT_RST;
    end else if (start_wr) begin
      // Load on start, restart or forced restart
      down_counter_ff <= reload_ff;
    end else if (enable_ff && !stop_wr && eff_edge) begin
      if (down_counter_ff == 32'h0000_0000) begin
        // Terminal count, reload and carry on
        down_counter_ff <= reload_ff;
      end else begin
        down_counter_ff <= down_counter_ff - 32'h0000_0001;
      end
    end
    // Stopped or no edge: value held
  end

  // Interrupt pulse on terminal count only; none at start
  always_ff @(posedge ref_clk) begin
    if (srst) begin
      irq_ff <= 1'b0;
    end else begin
      irq_ff <= !start_wr && !stop_wr && enable_ff && eff_edge && down_counter_ff == 32'h0000_0000;
    end
  end
  assign channel_interrupt = irq_ff;

  // Output pin unused in this mode
  assign channel_output = 1'b0;

  // ==========================================================
  // Assertions
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (srst);

  property p_start_load;
    start_wr |=> enable_ff && down_counter_ff == $past(reload_ff);
  endproperty
  a_start_load: assert property (p_start_load) else $error("start did not load counter");

  property p_decrement;
    enable_ff && eff_edge && !start_wr && !stop_wr && down_counter_ff != 32'h0000_0000
      |=> down_counter_ff == $past(down_counter_ff) - 32'h0000_0001 && !channel_interrupt;
  endproperty
  a_decrement: assert property (p_decrement) else $error("edge did not decrement");

  property p_terminal;
    enable_ff && eff_edge && !start_wr && !stop_wr && down_counter_ff == 32'h0000_0000
      |=> channel_interrupt && down_counter_ff == $past(reload_ff);
  endproperty
  a_terminal: assert property (p_terminal) else $error("terminal count missed");

  property p_stop;
    stop_wr |=> !enable_ff ##1 (!enable_ff || $past(start_wr));
  endproperty
  a_stop: assert property (p_stop) else $error("stop did not clear enable");

  property p_hold_stopped;
    !enable_ff && !start_wr |=> $stable(down_counter_ff) && !channel_interrupt;
  endproperty
  a_hold_stopped: assert property (p_hold_stopped) else $error("stopped counter moved");

  property p_hold_no_edge;
    !eff_edge && !start_wr |=> $stable(down_counter_ff);
  endproperty
  a_hold_no_edge: assert property (p_hold_no_edge) else $error("counter moved without edge");

  property p_rise_only;
    edge_select == event_count_pkg::EDGE_RISE && eff_edge |-> sync3_ff && !level_ff;
  endproperty
  a_rise_only: assert property (p_rise_only) else $error("rise select took wrong edge");

  property p_fall_only;
    edge_select == event_count_pkg::EDGE_FALL && eff_edge |-> !sync3_ff && level_ff;
  endproperty
  a_fall_only: assert property (p_fall_only) else $error("fall select took wrong edge");

  property p_irq_cause;
    channel_interrupt |-> $past(eff_edge) && $past(enable_ff) && $past(down_counter_ff) == 32'h0000_0000;
  endproperty
  a_irq_cause: assert property (p_irq_cause) else $error("interrupt without terminal edge");

  property p_bus_answer;
    bus_req && avs_waitrequest |=> !avs_waitrequest;
  endproperty
  a_bus_answer: assert property (p_bus_answer) else $error("bus answer late");

  property p_out_idle;
    !channel_output;
  endproperty
  a_out_idle: assert property (p_out_idle) else $error("channel output driven");

  c_terminal: cover property (enable_ff && eff_edge && down_counter_ff == 32'h0000_0000);
  c_forced: cover property (enable_ff && start_wr);
  c_restart: cover property (stop_wr ##[1:20] start_wr);
  c_both: cover property (edge_select == event_count_pkg::EDGE_BOTH && eff_edge);

endmodule

`default_nettype wire

// ==== sim/event_source.sv ====
// Behavioural source for the channel's event pin: clean pulses of a set width.
// Assumes the bench calls pulse() just after a rising edge of ref_clk.
`timescale 1ns/10ps
`default_nettype none

module event_source (
  // Clock
  input wire logic ref_clk,
  // Event pin towards the channel
  output logic event_input
);

  // ==========================================================
  // Pin idles low, so no edge is seen at start-up
  initial event_input = 1'b0;

  // ==========================================================
  // Pulses of hold cycles per level; hold must cover three tap periods
  task automatic pulse(input int n, input int hold);
    repeat (n) begin
      @(posedge ref_clk);
      event_input <= 1'b1; // Rising edge, count clock source
      repeat (hold) @(posedge ref_clk);
      event_input <= 1'b0; // Falling edge
      repeat (hold - 1) @(posedge ref_clk);
    end
    // Let the synchroniser and counter settle before anyone reads
    repeat (hold + 6) @(posedge ref_clk);
  endtask

endmodule

`default_nettype wire

// ==== sim/test_external_event_counter.sv ====
// Self-checking bench for the external event count channel.
// Assumes the design package is compiled first; drives Avalon-MM and the event pin.
`timescale 1ns/10ps
`default_nettype none

module test_external_event_counter;

  // ==========================================================
  // Signals
  logic ref_clk, srst, avs_read, avs_write, avs_waitrequest;
  logic [2:0] avs_address;
  logic [31:0] avs_writedata, avs_readdata;
  logic [3:0] avs_byteenable;
  logic event_input, channel_interrupt, channel_output;
  int num_errors, n_tests, irq_cnt, base, p, n;
  logic [31:0] rd, cnt, rel, k;
  localparam logic [31:0] MODE_EVT = 32'h0000_1006; // Event count, tap 0, software start

  // ==========================================================
  // Instances
  external_event_counter i_external_event_counter (.ref_clk(ref_clk), .srst(srst), .avs_address(avs_address),
    .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .event_input(event_input),
    .channel_interrupt(channel_interrupt), .channel_output(channel_output));
  event_source i_event_source (.ref_clk(ref_clk), .event_input(event_input));

  // ==========================================================
  // 200 MHz clock
  initial ref_clk = 1'b0;
  always #2.5 ref_clk = ~ref_clk;

  // Interrupt pulses counted one per high cycle
  initial irq_cnt = 0;
  always @(posedge ref_clk) begin
    if (channel_interrupt === 1'b1) begin
      irq_cnt <= irq_cnt + 1;
    end
  end

  // ==========================================================
  // Bus tasks: hold the request until waitrequest is sampled low
  task automatic bus_xfer(input logic wr, input logic [2:0] a, input logic [31:0] d, output logic [31:0] q);
    int w;
    w = 0;
    avs_address <= a;
    avs_writedata <= d;
    if (wr) avs_write <= 1'b1;
    else avs_read <= 1'b1;
    @(posedge ref_clk);
    while (avs_waitrequest !== 1'b0 && w < 50) begin
      @(posedge ref_clk);
      w++;
    end
    // A stuck slave is a mismatch, not a silent hang
    if (w >= 50) begin
      num_errors++;
      $display("[FAIL] waitrequest expected 0 seen %b", avs_waitrequest);
    end
    q = avs_readdata;
    avs_write <= 1'b0;
    avs_read <= 1'b0;
    // Idle edge so the next request never lands in the same step
    @(posedge ref_clk);
  endtask

  task automatic bus_wr(input logic [2:0] a, input logic [31:0] d);
    logic [31:0] q;
    bus_xfer(1'b1, a, d, q);
  endtask

  task automatic bus_rd(input logic [2:0] a, output logic [31:0] q);
    bus_xfer(1'b0, a, 32'h0, q);
  endtask

  // ==========================================================
  // Compare and closing
  task automatic chk32(input string what, input logic [31:0] exp, input logic [31:0] got);
    n_tests++;
    if (got !== exp) begin
      num_errors++;
      $display("[FAIL] %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic rd_chk(input string what, input logic [2:0] a, input logic [31:0] exp);
    logic [31:0] q;
    bus_rd(a, q);
    chk32(what, exp, q);
  endtask

  task automatic close_out;
    $display("checks %0d mismatches %0d", n_tests, num_errors);
    if (num_errors == 0 && n_tests > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask

  // Expected counter after n edges from c; returns interrupts raised
  function automatic logic [31:0] advance(inout logic [31:0] c, input logic [31:0] r, input int n);
    logic [31:0] irqs;
    irqs = 32'h0;
    for (int i = 0; i < n; i++) begin
      if (c == 32'h0) begin
        c = r;
        irqs++;
      end else begin
        c--;
      end
    end
    return irqs;
  endfunction

  // ==========================================================
  // Watchdog: whole run needs about 4000 cycles
  initial begin
    repeat (60000) @(posedge ref_clk);
    $display("[FAIL] watchdog expected done seen hang");
    num_errors++;
    close_out;
  end

  // ==========================================================
  // Main sequence
  initial begin
    num_errors = 0;
    n_tests = 0;
    void'($urandom(40307));
    srst = 1'b1;
    avs_read = 1'b0;
    avs_write = 1'b0;
    avs_address = 3'h0;
    avs_writedata = 32'h0;
    avs_byteenable = 4'hf;
    repeat (6) @(posedge ref_clk);
    srst <= 1'b0;
    @(posedge ref_clk);
    // Reset values, plus the unmapped word at 7
    for (int a = 0; a < 8; a++) begin
      rd_chk("reset", a[2:0], 32'h0);
    end
    // Channel set up for event counting; bit 5 must read back zero
    bus_wr(event_count_pkg::ADDR_MODE_CFG, MODE_EVT | 32'h20);
    rd_chk("mode", event_count_pkg::ADDR_MODE_CFG, MODE_EVT);
    bus_wr(3'h7, 32'hffff_ffff);
    rd_chk("unmapped", 3'h7, 32'h0);
    bus_wr(event_count_pkg::ADDR_EDGE_CFG, 32'h1);
    // Random reloads and edge counts, wrapping through zero
    for (int i = 0; i < 5; i++) begin
      rel = 32'h1 + $urandom % 6;
      n = $urandom % 15;
      bus_wr(event_count_pkg::ADDR_RELOAD, rel);
      bus_wr(event_count_pkg::ADDR_START, 32'h1);
      rd_chk("enable", event_count_pkg::ADDR_ENABLE, 32'h1);
      rd_chk("start bit", event_count_pkg::ADDR_START, 32'h0);
      bus_wr(event_count_pkg::ADDR_COUNTER, 32'hffff); // Read-only, must be ignored
      rd_chk("load", event_count_pkg::ADDR_COUNTER, rel);
      base = irq_cnt;
      cnt = rel;
      k = advance(cnt, rel, n);
      i_event_source.pulse(n, 8);
      rd_chk("count", event_count_pkg::ADDR_COUNTER, cnt);
      chk32("irqs", k, 32'(irq_cnt - base));
    end
    // Every edge select code, started fresh each time
    for (int e = 0; e < 4; e++) begin
      p = 1 + $urandom % 4;
      bus_wr(event_count_pkg::ADDR_EDGE_CFG, 32'(e));
      bus_wr(event_count_pkg::ADDR_RELOAD, 32'd100);
      bus_wr(event_count_pkg::ADDR_START, 32'h1);
      i_event_source.pulse(p, 8);
      k = (e == 2) ? 32'(2 * p) : (e == 3) ? 32'h0 : 32'(p);
      rd_chk("edge sel", event_count_pkg::ADDR_COUNTER, 32'd100 - k);
    end
    // New reload only at the next reload
    bus_wr(event_count_pkg::ADDR_EDGE_CFG, 32'h1);
    bus_wr(event_count_pkg::ADDR_RELOAD, 32'h2);
    bus_wr(event_count_pkg::ADDR_START, 32'h1);
    i_event_source.pulse(1, 8);
    bus_wr(event_count_pkg::ADDR_RELOAD, 32'h5);
    rd_chk("no early reload", event_count_pkg::ADDR_COUNTER, 32'h1);
    i_event_source.pulse(2, 8);
    rd_chk("late reload", event_count_pkg::ADDR_COUNTER, 32'h5);
    // Forced restart while running, then waits for the next edge
    bus_wr(event_count_pkg::ADDR_RELOAD, 32'h3);
    bus_wr(event_count_pkg::ADDR_START, 32'h1);
    rd_chk("forced", event_count_pkg::ADDR_COUNTER, 32'h3);
    i_event_source.pulse(1, 8);
    rd_chk("after forced", event_count_pkg::ADDR_COUNTER, 32'h2);
    // Stop: edges ignored, value kept
    bus_wr(event_count_pkg::ADDR_STOP, 32'h1);
    rd_chk("stopped", event_count_pkg::ADDR_ENABLE, 32'h0);
    rd_chk("stop bit", event_count_pkg::ADDR_STOP, 32'h0);
    base = irq_cnt;
    i_event_source.pulse(3, 8);
    rd_chk("held", event_count_pkg::ADDR_COUNTER, 32'h2);
    chk32("stop irqs", 32'h0, 32'(irq_cnt - base));
    // Restart from stopped reloads
    bus_wr(event_count_pkg::ADDR_START, 32'h1);
    rd_chk("restart", event_count_pkg::ADDR_COUNTER, 32'h3);
    i_event_source.pulse(1, 8);
    rd_chk("resumed", event_count_pkg::ADDR_COUNTER, 32'h2);
    // Reload of zero: one interrupt per edge
    bus_wr(event_count_pkg::ADDR_RELOAD, 32'h0);
    bus_wr(event_count_pkg::ADDR_START, 32'h1);
    base = irq_cnt;
    i_event_source.pulse(3, 8);
    chk32("zero irqs", 32'h3, 32'(irq_cnt - base));
    rd_chk("zero cnt", event_count_pkg::ADDR_COUNTER, 32'h0);
    // Slower prescaler taps still count; pulses widened to suit
    for (int t = 1; t < 4; t++) begin
      bus_wr(event_count_pkg::ADDR_MODE_CFG, MODE_EVT | (32'(t) << 14));
      bus_wr(event_count_pkg::ADDR_RELOAD, 32'd50);
      bus_wr(event_count_pkg::ADDR_START, 32'h1);
      i_event_source.pulse(2, (4 << (2 * t)) + 4);
      rd_chk("tap", event_count_pkg::ADDR_COUNTER, 32'd48);
    end
    // Partial write: only byte lane 1 of reload_data may change
    avs_byteenable <= 4'h2;
    bus_wr(event_count_pkg::ADDR_RELOAD, 32'h1234_aa00);
    avs_byteenable <= 4'hf;
    rd_chk("lane write", event_count_pkg::ADDR_RELOAD, 32'h0000_aa32);
    chk32("output pin", 32'h0, {31'h0, channel_output});
    close_out;
  end

endmodule

`default_nettype wire
